// [verification/rie_dmem_model.sv]
// Data memory seen by the execute core
`timescale 1ns/1ns
`default_nettype none
module rie_dmem_model (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [15:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_r [256];
  initial for (int k = 0; k < 256; k++) mem_r[k] = k[7:0] ^ 8'h5A;
  // Write lands at the strobe edge, so a load one cycle later still sees old data
  always @(posedge i_core_clk) if (i_we) mem_r[i_addr[7:0]] <= i_wdata;
  assign o_rdata = mem_r[i_raddr[7:0]];
endmodule : rie_dmem_model
`default_nettype wire

// [verification/rie_exec_core_tb.sv]
// Random instruction stream against a reference model of the core
`timescale 1ns/1ns
`default_nettype none
module rie_exec_core_tb;
  typedef struct packed {
    logic [15:0] pc; logic [15:0] ip; logic [15:0] top; logic [7:0] acc; logic c, z, g;
    logic w; logic [15:0] da; logic [7:0] dd;
  } rie_note_t;
  logic core_clk, rst_n, valid, use_ip, done, zero, carry, global_irq_enable, dm_we;
  rie_pkg::rie_op_t op;
  rie_pkg::rie_src_t src_kind;
  rie_pkg::rie_cond_t cond_sel;
  logic [3:0] dst_sel, src_sel;
  logic [15:0] imm_addr, eaddr, pc, pidx, stop, dm_addr;
  logic [7:0] imm_data, dm_rdata, acc, dm_wdata;
  logic [15:0] m_pc, m_ip, m_da;
  logic [7:0] m_dd;
  logic [7:0] m_r [16];
  logic [7:0] m_mem [256];
  logic m_c, m_z, m_g, pnd;
  logic [7:0] pnd_a, pnd_d;
  logic [15:0] stk[$];
  rie_note_t notes[$];
  rie_note_t nt;
  int miscompares, total_checks;
  rie_exec_core u_rie_exec_core (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_valid(valid),
    .i_op(op), .i_src_kind(src_kind), .i_cond_sel(cond_sel), .i_use_ip(use_ip),
    .i_dst_sel(dst_sel), .i_src_sel(src_sel), .i_imm_addr(imm_addr), .i_imm_data(imm_data),
    .i_eaddr(eaddr), .i_dm_rdata(dm_rdata), .o_done(done), .o_pc(pc), .o_acc(acc),
    .o_zero(zero), .o_carry(carry), .o_gie(global_irq_enable), .o_program_index(pidx),
    .o_stack_top(stop), .o_dm_we(dm_we), .o_dm_addr(dm_addr), .o_dm_wdata(dm_wdata));
  rie_dmem_model u_rie_dmem_model (.i_core_clk(core_clk), .i_we(dm_we), .i_addr(dm_addr),
    .i_wdata(dm_wdata), .i_raddr(eaddr), .o_rdata(dm_rdata));
  task automatic cmp16(input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp16
  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    cmp16({8'h00, e}, {8'h00, g});
  endtask : cmp8
  task automatic cmp1(input logic e, input logic g);
    cmp16({15'h0000, e}, {15'h0000, g});
  endtask : cmp1
  task automatic issue();
    logic [7:0] s, a;
    logic [15:0] t;
    logic tk, ci, pn;
    logic [7:0] pa, pd;
    pn = 1'b0; pa = 8'h00; pd = 8'h00;
    valid = ($urandom % 5) != 0;
    op = rie_pkg::rie_op_t'($urandom % 26);
    src_kind = rie_pkg::rie_src_t'($urandom % 3);
    cond_sel = rie_pkg::rie_cond_t'($urandom % 4);
    use_ip = 1'($urandom);
    dst_sel = 4'($urandom % 4);
    src_sel = ($urandom % 5 == 0) ? 4'hF : 4'($urandom % 4);
    imm_addr = 16'($urandom);
    imm_data = 8'($urandom);
    eaddr = {8'h00, 8'($urandom)};
    // Keep the stack within its depth, overflow is undefined
    if (op inside {rie_pkg::OP_RET, rie_pkg::OP_RETI, rie_pkg::OP_POP} && stk.size() == 0)
      op = rie_pkg::OP_PUSH;
    if (op inside {rie_pkg::OP_CALL, rie_pkg::OP_PUSH} && stk.size() >= 7) op = rie_pkg::OP_POP;
    s = src_kind == rie_pkg::SRC_IMM ? imm_data :
        src_kind == rie_pkg::SRC_REG ? m_r[src_sel] : m_mem[eaddr[7:0]];
    t = use_ip ? m_ip : imm_addr;
    if (valid) begin
      ci = m_c;
      a = m_r[15];
      m_pc = m_pc + 16'h0001;
      tk = (cond_sel == rie_pkg::COND_Z && m_z) || (cond_sel == rie_pkg::COND_NZ && !m_z) ||
           (cond_sel == rie_pkg::COND_C && m_c) || (cond_sel == rie_pkg::COND_NC && !m_c);
      case (op)
        rie_pkg::OP_JUMP: m_pc = t;
        rie_pkg::OP_JCC: if (tk) m_pc = t;
        rie_pkg::OP_CALL: begin stk.push_front(m_pc); m_pc = t; end
        rie_pkg::OP_CALLS: begin m_ip = m_pc; m_pc = t; end
        rie_pkg::OP_RET: m_pc = stk.pop_front();
        rie_pkg::OP_RETS: m_pc = m_ip;
        rie_pkg::OP_RETI: begin m_pc = stk.pop_front(); m_g = 1'b1; end
        rie_pkg::OP_PUSH: stk.push_front(m_ip);
        rie_pkg::OP_POP: m_ip = stk.pop_front();
        rie_pkg::OP_STORE: begin
          pn = 1'b1; pa = eaddr[7:0]; pd = m_r[src_sel]; m_da = eaddr; m_dd = pd;
        end
        rie_pkg::OP_STORE_IMM: begin
          pn = 1'b1; pa = imm_addr[7:0]; pd = imm_data; m_da = {8'h00, pa}; m_dd = pd;
        end
        rie_pkg::OP_MOVE: a = s;
        rie_pkg::OP_CMVD: begin a = s; if (!m_c) m_r[dst_sel] = s; end
        rie_pkg::OP_CMVS: begin a = s; if (m_c) m_r[dst_sel] = s; end
        rie_pkg::OP_SHL: {m_c, a} = {s, 1'b0};
        rie_pkg::OP_SHLC: {m_c, a} = {s, ci};
        rie_pkg::OP_SHR: {a, m_c} = {1'b0, s};
        rie_pkg::OP_SHRC: {a, m_c} = {ci, s};
        rie_pkg::OP_SHRA: {a, m_c} = {s[7], s};
        rie_pkg::OP_ONES_COMPLEMENT: a = ~s;
        rie_pkg::OP_TWOS_COMPLEMENT: begin a = ~s + 8'h01; m_c = a == 8'h00; end
        rie_pkg::OP_TWOS_COMPLEMENT_WITH_CARRY: begin a = ~s + {7'h00, ci}; m_c = ci && a == 8'h00; end
        rie_pkg::OP_INC: begin a = s + 8'h01; m_c = a == 8'h00; end
        rie_pkg::OP_INCC: begin a = s + {7'h00, ci}; m_c = ci && a == 8'h00; end
        rie_pkg::OP_DEC: begin a = s - 8'h01; m_c = a != 8'hFF; end
        default: ;
      endcase
      if (op inside {[rie_pkg::OP_CMVD:rie_pkg::OP_DEC], rie_pkg::OP_MOVE}) begin
        if (op != rie_pkg::OP_CMVD && op != rie_pkg::OP_CMVS) m_r[dst_sel] = a;
        m_r[15] = a;
        m_z = a == 8'h00;
      end
      notes.push_back('{m_pc, m_ip, stk.size() ? stk[0] : 16'h0000, m_r[15], m_c, m_z, m_g,
                        pn, m_da, m_dd});
    end
    if (pnd) m_mem[pnd_a] = pnd_d;
    {pnd, pnd_a, pnd_d} = {pn, pa, pd};
  endtask : issue
  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    #2;
    if (done === 1'b1) begin
      if (notes.size() == 0) miscompares++;
      else begin
        nt = notes.pop_front();
        cmp16(nt.pc, pc);
        cmp16(nt.ip, pidx);
        cmp16(nt.top, stop);
        cmp8(nt.acc, acc);
        cmp1(nt.c, carry);
        cmp1(nt.z, zero);
        cmp1(nt.g, global_irq_enable);
        cmp1(nt.w, dm_we);
        cmp16(nt.da, dm_addr);
        cmp8(nt.dd, dm_wdata);
      end
    end
  end
  initial begin
    void'($urandom(32'h5542));
    {rst_n, valid, use_ip, dst_sel, src_sel, imm_addr, imm_data, eaddr} = '0;
    op = rie_pkg::OP_NOP;
    src_kind = rie_pkg::SRC_IMM;
    cond_sel = rie_pkg::COND_Z;
    {m_pc, m_ip, m_c, m_z, m_g, pnd, pnd_a, pnd_d, m_da, m_dd} = '0;
    miscompares = 0;
    total_checks = 0;
    foreach (m_r[k]) m_r[k] = 8'h00;
    for (int k = 0; k < 256; k++) m_mem[k] = k[7:0] ^ 8'h5A;
    repeat (8) @(posedge core_clk);
    #5 rst_n = 1'b1;
    repeat (800) begin
      @(posedge core_clk);
      #5 issue();
    end
    @(posedge core_clk);
    #5 valid = 1'b0;
    for (int n = 0; n < 10 && notes.size() != 0; n++) @(posedge core_clk);
    if (notes.size() != 0) miscompares++;
    results();
  end
endmodule : rie_exec_core_tb
`default_nettype wire

// [verification/rie_exec_monitor.sv]
// Port assertions for the execute core
`timescale 1ns/1ns
`default_nettype none
module rie_exec_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire rie_pkg::rie_op_t i_op,
  input wire logic i_use_ip,
  input wire logic [15:0] i_imm_addr,
  input wire logic [15:0] i_eaddr,
  input wire logic o_done,
  input wire logic [15:0] o_pc,
  input wire logic [7:0] o_acc,
  input wire logic o_zero,
  input wire logic o_gie,
  input wire logic [15:0] o_program_index,
  input wire logic [15:0] o_stack_top,
  input wire logic o_dm_we,
  input wire logic [15:0] o_dm_addr
);
  logic [4:0] op_v;
  // Undefined code stands for no instruction
  assign op_v = i_valid ? i_op : 5'h1F;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  chk_done_follows: assert property (i_valid |=> o_done)
    else $error("no done after instruction");
  chk_idle_hold: assert property (!i_valid |=> !o_done && $stable(o_pc))
    else $error("idle cycle changed state");
  chk_jump_target: assert property (op_v == rie_pkg::OP_JUMP && !i_use_ip |=>
    o_pc == $past(i_imm_addr)) else $error("jump target wrong");
  chk_call_stack: assert property (op_v == rie_pkg::OP_CALL |=>
    o_stack_top == $past(o_pc) + 16'h0001) else $error("call return address wrong");
  chk_calls_index: assert property (op_v == rie_pkg::OP_CALLS |=>
    o_program_index == $past(o_pc) + 16'h0001) else $error("index call save wrong");
  chk_ret_pop: assert property (op_v == rie_pkg::OP_RET |=>
    o_pc == $past(o_stack_top)) else $error("return address wrong");
  chk_reti_gie: assert property (op_v == rie_pkg::OP_RETI |=> o_gie)
    else $error("interrupt enable not set");
  chk_push_top: assert property (op_v == rie_pkg::OP_PUSH |=>
    o_stack_top == $past(o_program_index)) else $error("push top wrong");
  chk_pop_index: assert property (op_v == rie_pkg::OP_POP |=>
    o_program_index == $past(o_stack_top)) else $error("pop index wrong");
  chk_store_strobe: assert property (op_v == rie_pkg::OP_STORE |=> o_dm_we &&
    o_dm_addr == $past(i_eaddr) && $stable(o_acc)) else $error("store wrong");
  chk_zero_track: assert property (op_v == rie_pkg::OP_MOVE |=>
    o_zero == (o_acc == 8'h00)) else $error("zero flag wrong");
endmodule : rie_exec_monitor
bind rie_exec_core rie_exec_monitor u_rie_exec_monitor (.i_core_clk, .i_rst_n, .i_valid,
  .i_op, .i_use_ip, .i_imm_addr, .i_eaddr, .o_done, .o_pc, .o_acc, .o_zero, .o_gie,
  .o_program_index, .o_stack_top, .o_dm_we, .o_dm_addr);
`default_nettype wire

// [verilog/rie_exec_core.sv]
// Execute stage: program flow, return stack, register moves and flags
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Jumps load PC with immediate or index; conditional ones only when condition holds.
// - Stack call pushes levels down, stores PC+1 on top, then jumps.
// - Index call saves PC+1 into the index register, jumps to target or old index.
// - Return pops PC from top level; index return loads PC from index register.
// - Interrupt return pops like return and sets global interrupt enable.
// - Push advances PC, shifts levels down, puts index on top level.
// - Pop advances PC, copies top level into index, shifts levels up.
// - Loads write destination and accumulator, update zero; stores leave flags alone.
// - Conditional moves always load accumulator; destination written on matching carry.
// - Logical left shift inserts zero at bit 0, old bit 7 to carry.
// - Left shift through carry inserts old carry at bit 0, bit 7 out.
// - Logical right shift inserts zero at bit 7, old bit 0 to carry.
// - Right shift through carry inserts old carry at bit 7, bit 0 out.
// - Arithmetic right shift keeps sign bit 7, old bit 0 to carry.
// - Ones complement writes inverted source, updates only zero flag.
// - Twos complement writes inverted plus one; carry set when result zero.
// - Twos complement with carry adds carry; carry out when zero and carry-in.
// - Increment adds one; carry set when result wraps to zero.
// - Increment with carry adds carry; carry out when zero and carry-in.
// - Decrement subtracts one; carry cleared on result FF, else set.
// - Every instruction completes in exactly one clock cycle.
// - Zero flag follows the accumulator result of flag-updating instructions.
module rie_exec_core (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire rie_pkg::rie_op_t i_op,
  input wire rie_pkg::rie_src_t i_src_kind,
  input wire rie_pkg::rie_cond_t i_cond_sel,
  input wire logic i_use_ip,
  input wire logic [3:0] i_dst_sel,
  input wire logic [3:0] i_src_sel,
  input wire logic [15:0] i_imm_addr,
  input wire logic [7:0] i_imm_data,
  input wire logic [15:0] i_eaddr,
  input wire logic [7:0] i_dm_rdata,
  output logic o_done,
  output logic [15:0] o_pc,
  output logic [7:0] o_acc,
  output logic o_zero,
  output logic o_carry,
  output logic o_gie,
  output logic [15:0] o_program_index,
  output logic [15:0] o_stack_top,
  output logic o_dm_we,
  output logic [15:0] o_dm_addr,
  output logic [7:0] o_dm_wdata
);

  localparam int DEPTH = rie_pkg::STACK_DEPTH;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0][7:0] regs;
    logic [DEPTH-1:0][15:0] return_stack_level;
    logic zero;
    logic carry;
    logic done;
    logic dm_we;
    logic [15:0] dm_addr;
    logic [7:0] dm_wdata;
  } rie_core_state_t;

  rie_core_state_t st_r;
  rie_core_state_t st_nxt;

  logic [7:0] src_val;
  logic [15:0] pc_inc;
  logic [15:0] program_index;
  logic [15:0] target;
  logic cond_true;
  logic [7:0] alu_res;
  logic alu_carry;
  logic alu_hit;
  logic [7:0] res_val;
  logic res_dst_we;
  logic res_acc_we;
  logic res_carry_we;
  logic res_carry;

  rie_unary_alu u_unary_alu (
    .i_op(i_op),
    .i_src(src_val),
    .i_carry(st_r.carry),
    .o_res(alu_res),
    .o_carry(alu_carry),
    .o_hit(alu_hit)
  );

  // Operand fetch: the data memory word arrives with the instruction
  always_comb begin
    unique case (i_src_kind)
      rie_pkg::SRC_IMM: src_val = i_imm_data;
      rie_pkg::SRC_REG: src_val = st_r.regs[i_src_sel];
      rie_pkg::SRC_DM: src_val = i_dm_rdata;
      default: src_val = i_dm_rdata;
    endcase
  end

  always_comb begin
    unique case (i_cond_sel)
      rie_pkg::COND_Z: cond_true = st_r.zero;
      rie_pkg::COND_NZ: cond_true = !st_r.zero;
      rie_pkg::COND_C: cond_true = st_r.carry;
      rie_pkg::COND_NC: cond_true = !st_r.carry;
      default: cond_true = 1'b0;
    endcase
  end

  assign pc_inc = 16'(st_r.pc + 16'h0001);
  assign program_index = {st_r.regs[rie_pkg::REG_IP_HI], st_r.regs[rie_pkg::REG_IP_LO]};
  // Target is sampled from the old index, so an index call can jump to it
  assign target = i_use_ip ? program_index : i_imm_addr;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.dm_we = 1'b0;
    res_val = src_val;
    res_dst_we = 1'b0;
    res_acc_we = 1'b0;
    res_carry_we = 1'b0;
    res_carry = st_r.carry;
    if (i_valid) begin
      // One instruction retires on every valid edge, taken branch or not
      st_nxt.done = 1'b1;
      st_nxt.pc = pc_inc;
      unique case (i_op)
        rie_pkg::OP_NOP: begin
        end
        rie_pkg::OP_JUMP: begin
          st_nxt.pc = target;
        end
        rie_pkg::OP_JCC: begin
          // Untaken branch falls through to the next word in the same cycle
          if (cond_true) begin
            st_nxt.pc = target;
          end
        end
        rie_pkg::OP_CALL: begin
          st_nxt.return_stack_level = {st_r.return_stack_level[DEPTH-2:0], pc_inc};
          st_nxt.pc = target;
        end
        rie_pkg::OP_CALLS: begin
          st_nxt.regs[rie_pkg::REG_IP_HI] = pc_inc[15:8];
          st_nxt.regs[rie_pkg::REG_IP_LO] = pc_inc[7:0];
          st_nxt.pc = target;
        end
        rie_pkg::OP_RET: begin
          st_nxt.pc = st_r.return_stack_level[0];
          st_nxt.return_stack_level = {16'h0000, st_r.return_stack_level[DEPTH-1:1]};
        end
        rie_pkg::OP_RETS: begin
          st_nxt.pc = program_index;
        end
        rie_pkg::OP_RETI: begin
          st_nxt.pc = st_r.return_stack_level[0];
          st_nxt.return_stack_level = {16'h0000, st_r.return_stack_level[DEPTH-1:1]};
          st_nxt.regs[rie_pkg::REG_STAT][rie_pkg::STAT_GIE_BIT] = 1'b1;
        end
        rie_pkg::OP_PUSH: begin
          st_nxt.return_stack_level = {st_r.return_stack_level[DEPTH-2:0], program_index};
        end
        rie_pkg::OP_POP: begin
          st_nxt.regs[rie_pkg::REG_IP_HI] = st_r.return_stack_level[0][15:8];
          st_nxt.regs[rie_pkg::REG_IP_LO] = st_r.return_stack_level[0][7:0];
          st_nxt.return_stack_level = {16'h0000, st_r.return_stack_level[DEPTH-1:1]};
        end
        rie_pkg::OP_MOVE: begin
          res_val = src_val;
          res_dst_we = 1'b1;
          res_acc_we = 1'b1;
        end
        rie_pkg::OP_STORE: begin
          // Register to memory; accumulator and flags stay put
          st_nxt.dm_we = 1'b1;
          st_nxt.dm_addr = i_eaddr;
          st_nxt.dm_wdata = st_r.regs[i_src_sel];
        end
        rie_pkg::OP_STORE_IMM: begin
          // Short form reaches only the first 256 bytes
          st_nxt.dm_we = 1'b1;
          st_nxt.dm_addr = {8'h00, i_imm_addr[7:0]};
          st_nxt.dm_wdata = i_imm_data;
        end
        rie_pkg::OP_CMVD: begin
          res_acc_we = 1'b1;
          res_dst_we = !st_r.carry;
        end
        rie_pkg::OP_CMVS: begin
          res_acc_we = 1'b1;
          res_dst_we = st_r.carry;
        end
        default: begin
          // Single-operand datapath; unknown codes retire as a plain step
          if (alu_hit) begin
            res_val = alu_res;
            res_dst_we = 1'b1;
            res_acc_we = 1'b1;
            res_carry_we = 1'b1;
            res_carry = alu_carry;
          end
        end
      endcase
      // Destination first, accumulator last: writing the accumulator as
      // destination then lands the same value twice, never two values
      if (res_dst_we) begin
        st_nxt.regs[i_dst_sel] = res_val;
      end
      if (res_acc_we) begin
        st_nxt.regs[rie_pkg::REG_ACC] = res_val;
        st_nxt.zero = (res_val == 8'h00);
      end
      if (res_carry_we) begin
        st_nxt.carry = res_carry;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{
        pc: rie_pkg::PC_RESET,
        regs: {16{rie_pkg::REG_RESET}},
        return_stack_level: '0,
        zero: 1'b0,
        carry: 1'b0,
        done: 1'b0,
        dm_we: 1'b0,
        dm_addr: 16'h0000,
        dm_wdata: 8'h00
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_done = st_r.done;
  assign o_pc = st_r.pc;
  assign o_acc = st_r.regs[rie_pkg::REG_ACC];
  assign o_zero = st_r.zero;
  assign o_carry = st_r.carry;
  assign o_gie = st_r.regs[rie_pkg::REG_STAT][rie_pkg::STAT_GIE_BIT];
  assign o_program_index = program_index;
  assign o_stack_top = st_r.return_stack_level[0];
  assign o_dm_we = st_r.dm_we;
  assign o_dm_addr = st_r.dm_addr;
  assign o_dm_wdata = st_r.dm_wdata;

endmodule : rie_exec_core

`default_nettype wire

// [verilog/rie_pkg.sv]
// Shared constants and types for the instruction execute block
package rie_pkg;

  localparam int REG_W = 8;
  localparam int PC_W = 16;
  localparam int STACK_DEPTH = 8;
  localparam logic [3:0] REG_IP_HI = 4'hC;
  localparam logic [3:0] REG_IP_LO = 4'hD;
  localparam logic [3:0] REG_STAT = 4'hE;
  localparam logic [3:0] REG_ACC = 4'hF;
  localparam int STAT_GIE_BIT = 5;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] DEC_BORROW_VAL = 8'hFF;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_JUMP = 5'h01,
    OP_JCC = 5'h02,
    OP_CALL = 5'h03,
    OP_CALLS = 5'h04,
    OP_RET = 5'h05,
    OP_RETS = 5'h06,
    OP_RETI = 5'h07,
    OP_PUSH = 5'h08,
    OP_POP = 5'h09,
    OP_MOVE = 5'h0A,
    OP_STORE = 5'h0B,
    OP_STORE_IMM = 5'h0C,
    OP_CMVD = 5'h0D,
    OP_CMVS = 5'h0E,
    OP_SHL = 5'h0F,
    OP_SHLC = 5'h10,
    OP_SHR = 5'h11,
    OP_SHRC = 5'h12,
    OP_SHRA = 5'h13,
    OP_ONES_COMPLEMENT = 5'h14,
    OP_TWOS_COMPLEMENT = 5'h15,
    OP_TWOS_COMPLEMENT_WITH_CARRY = 5'h16,
    OP_INC = 5'h17,
    OP_INCC = 5'h18,
    OP_DEC = 5'h19
  } rie_op_t;

  typedef enum logic [1:0] {
    SRC_IMM = 2'b00,
    SRC_REG = 2'b01,
    SRC_DM = 2'b10
  } rie_src_t;

  typedef enum logic [1:0] {
    COND_Z = 2'b00,
    COND_NZ = 2'b01,
    COND_C = 2'b10,
    COND_NC = 2'b11
  } rie_cond_t;

endpackage : rie_pkg

// [verilog/rie_unary_alu.sv]
// Single-operand datapath: shifts, complements, increment and decrement
`timescale 1ns/1ns
`default_nettype none

module rie_unary_alu (
  input wire rie_pkg::rie_op_t i_op,
  input wire logic [7:0] i_src,
  input wire logic i_carry,
  output logic [7:0] o_res,
  output logic o_carry,
  output logic o_hit
);

  always_comb begin
    o_res = i_src;
    o_carry = i_carry;
    o_hit = 1'b1;
    unique case (i_op)
      rie_pkg::OP_SHL: begin
        o_res = {i_src[6:0], 1'b0};
        o_carry = i_src[7];
      end
      rie_pkg::OP_SHLC: begin
        o_res = {i_src[6:0], i_carry};
        o_carry = i_src[7];
      end
      rie_pkg::OP_SHR: begin
        o_res = {1'b0, i_src[7:1]};
        o_carry = i_src[0];
      end
      rie_pkg::OP_SHRC: begin
        o_res = {i_carry, i_src[7:1]};
        o_carry = i_src[0];
      end
      rie_pkg::OP_SHRA: begin
        o_res = {i_src[7], i_src[7:1]};
        o_carry = i_src[0];
      end
      rie_pkg::OP_ONES_COMPLEMENT: begin
        o_res = ~i_src;
      end
      rie_pkg::OP_TWOS_COMPLEMENT: begin
        o_res = 8'((~i_src) + 8'h01);
        o_carry = (o_res == 8'h00);
      end
      rie_pkg::OP_TWOS_COMPLEMENT_WITH_CARRY: begin
        o_res = 8'((~i_src) + {7'h00, i_carry});
        o_carry = (o_res == 8'h00) && i_carry;
      end
      rie_pkg::OP_INC: begin
        o_res = 8'(i_src + 8'h01);
        o_carry = (o_res == 8'h00);
      end
      rie_pkg::OP_INCC: begin
        o_res = 8'(i_src + {7'h00, i_carry});
        o_carry = (o_res == 8'h00) && i_carry;
      end
      rie_pkg::OP_DEC: begin
        o_res = 8'(i_src - 8'h01);
        o_carry = (o_res != rie_pkg::DEC_BORROW_VAL);
      end
      default: begin
        o_hit = 1'b0;
      end
    endcase
  end

endmodule : rie_unary_alu

`default_nettype wire
